// *** timer0_defines.svh ***
`ifndef TIMER0_DEFINES_SVH
`define TIMER0_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Register word indices; the byte address is four times the index.
`define IDX_CMP_B 6'h28
`define IDX_CMP_A 6'h29
`define IDX_CTRL_A 6'h2a
`define IDX_COUNT 6'h32
`define IDX_CTRL_B 6'h33
`define IDX_FLAGS 6'h38
`define IDX_MASK 6'h39
`define ADDR_IDX_MSB 7
`define ADDR_IDX_LSB 2
////////////////////////////////////////////////////////////////////////////////
// Reset values and the control A write mask.
`define REG_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define CTRL_A_WR_MASK 8'hf3
`define WORD_ZERO 32'h0000_0000
////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6
`define WAVE_HI_BIT 3
`define CS_MSB 2
`define CS_LSB 0
`define OUT_A_MSB 7
`define OUT_A_LSB 6
`define OUT_B_MSB 5
`define OUT_B_LSB 4
`define WAVE_LO_MSB 1
`define WAVE_LO_LSB 0
`define IRQ_A_BIT 4
`define IRQ_B_BIT 3
`define IRQ_OVF_BIT 1
////////////////////////////////////////////////////////////////////////////////
// Clock source codes.
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
////////////////////////////////////////////////////////////////////////////////
// Waveform modes and output modes.
`define WM_NORMAL 3'h0
`define WM_PHASE_FF 3'h1
`define WM_CLEAR_ON_MATCH 3'h2
`define WM_FAST_FF 3'h3
`define WM_PHASE_CMP 3'h5
`define WM_FAST_CMP 3'h7
`define OM_OFF 2'h0
`define OM_TOGGLE 2'h1
`define OM_CLEAR 2'h2
`define OM_SET 2'h3
////////////////////////////////////////////////////////////////////////////////
// Count limits and prescaler taps.
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define COUNT_ONE 8'h01
`define PRE_DIV8_MSB 2
`define PRE_DIV64_MSB 5
`define PRE_DIV256_MSB 7
`define PRE_DIV1024_MSB 9
`define PRE_MIN_WIDTH 10
`endif

// *** timer0_pkg.sv ***
package timer0_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic tick8;
		logic tick64;
		logic tick256;
		logic tick1024;
	} pre_taps_t;

endpackage

// *** timer0_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defines.svh"

module timer0_prescaler #(
	parameter int Width = 10
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Divided tick pulses.
	output timer0_pkg::pre_taps_t taps
);

	if (Width < `PRE_MIN_WIDTH) begin : gWidthCheck
		$error("Prescaler width too small for the largest division.");
	end

	logic [Width-1:0] preQ;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			preQ <= '0;
		end else begin
			preQ <= preQ + 1'b1;
		end
	end

	// Each tap pulses once per period of its division.
	assign taps.tick8 = &preQ[`PRE_DIV8_MSB:0];
	assign taps.tick64 = &preQ[`PRE_DIV64_MSB:0];
	assign taps.tick256 = &preQ[`PRE_DIV256_MSB:0];
	assign taps.tick1024 = &preQ[`PRE_DIV1024_MSB:0];

endmodule // timer0_prescaler
`default_nettype wire

// *** timer0_control_and_flags.sv ***
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defines.svh"

module timer0_control_and_flags #(
	parameter int PreWidth = 10
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus.
	input wire timer0_pkg::apb_req_t apbReq,
	output timer0_pkg::apb_rsp_t apbRsp,
	// Interrupt gating and vector acknowledges.
	input wire logic globalIrqEn,
	input wire logic ackCmpA,
	input wire logic ackCmpB,
	input wire logic ackOvf,
	// Interrupt requests.
	output logic irqCmpA,
	output logic irqCmpB,
	output logic irqOvf,
	// External count pin.
	input wire logic extCountPin,
	// Waveform outputs and their connect enables.
	output logic waveOutA,
	output logic waveOutB,
	output logic waveConnA,
	output logic waveConnB
);

	////////////////////////////////////////////////////////////////////////////
	// Output action for one channel on a tick or a forced compare.
	function automatic logic waveNext(
		input logic cur,
		input logic [1:0] om,
		input logic hit,
		input logic force_,
		input logic bottom,
		input logic phase,
		input logic fast,
		input logic upDir
	);
		logic nxt;
		nxt = cur;
		if (!phase && !fast) begin
			if (hit || force_) begin
				unique case (om)
					`OM_OFF: nxt = cur;
					`OM_TOGGLE: nxt = ~cur;
					`OM_CLEAR: nxt = 1'b0;
					`OM_SET: nxt = 1'b1;
				endcase
			end
		end else if (fast) begin
			if (hit && om == `OM_CLEAR) begin
				nxt = 1'b0;
			end
			if (hit && om == `OM_SET) begin
				nxt = 1'b1;
			end
			if (bottom && om == `OM_CLEAR) begin
				nxt = 1'b1;
			end
			if (bottom && om == `OM_SET) begin
				nxt = 1'b0;
			end
		end else begin
			if (hit && om == `OM_CLEAR) begin
				nxt = ~upDir;
			end
			if (hit && om == `OM_SET) begin
				nxt = upDir;
			end
		end
		return nxt;
	endfunction

	// Next flag value; a hardware set wins over a clear in the same cycle.
	function automatic logic flagNext(
		input logic cur,
		input logic set,
		input logic clr
	);
		return (cur & ~clr) | set;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers.
	logic [7:0] ctrlAQ;
	logic waveHiQ;
	logic [2:0] clkSelQ;
	logic [7:0] countQ;
	logic [7:0] countD;
	logic [7:0] cmpAQ;
	logic [7:0] cmpBQ;
	logic cmpAIrqEnQ;
	logic cmpBIrqEnQ;
	logic ovfIrqEnQ;
	logic cmpAFlagQ;
	logic cmpBFlagQ;
	logic ovfFlagQ;
	logic upQ;
	logic upD;
	logic blockQ;
	logic waveAQ;
	logic waveBQ;
	logic extSync1Q;
	logic extSync2Q;
	logic extPrevQ;
	logic [31:0] prdataQ;
	logic errQ;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.
	wire logic [5:0] regIdx = apbReq.paddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	wire logic setupPh = apbReq.psel & ~apbReq.penable;
	wire logic accessPh = apbReq.psel & apbReq.penable;
	wire logic wrEn = accessPh & apbReq.pwrite;
	wire logic [7:0] wData = apbReq.pwdata[7:0];
	wire logic selCtrlA = regIdx == `IDX_CTRL_A;
	wire logic selCtrlB = regIdx == `IDX_CTRL_B;
	wire logic selCount = regIdx == `IDX_COUNT;
	wire logic selCmpA = regIdx == `IDX_CMP_A;
	wire logic selCmpB = regIdx == `IDX_CMP_B;
	wire logic selMask = regIdx == `IDX_MASK;
	wire logic selFlags = regIdx == `IDX_FLAGS;
	wire logic mapped = selCtrlA | selCtrlB | selCount | selCmpA | selCmpB | selMask | selFlags;
	wire logic wrCtrlB = wrEn & selCtrlB;
	wire logic wrCount = wrEn & selCount;
	wire logic wrFlags = wrEn & selFlags;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode.
	wire logic [2:0] waveMode = {waveHiQ, ctrlAQ[`WAVE_LO_MSB:`WAVE_LO_LSB]};
	wire logic [1:0] outModeA = ctrlAQ[`OUT_A_MSB:`OUT_A_LSB];
	wire logic [1:0] outModeB = ctrlAQ[`OUT_B_MSB:`OUT_B_LSB];
	wire logic isPhase = waveMode == `WM_PHASE_FF || waveMode == `WM_PHASE_CMP;
	wire logic isFast = waveMode == `WM_FAST_FF || waveMode == `WM_FAST_CMP;
	wire logic isPwm = isPhase | isFast;
	wire logic topIsCmpA = waveMode == `WM_CLEAR_ON_MATCH || waveMode == `WM_PHASE_CMP
		|| waveMode == `WM_FAST_CMP;
	wire logic [7:0] topVal = topIsCmpA ? cmpAQ : `COUNT_MAX;
	wire logic atTop = countQ == topVal;
	wire logic atBottom = countQ == `COUNT_BOTTOM;

	////////////////////////////////////////////////////////////////////////////
	// Count clock selection.
	timer0_pkg::pre_taps_t taps;

	timer0_prescaler #(
		.Width(PreWidth)
	) uPrescaler (
		.clk(clk),
		.sys_rst(sys_rst),
		.taps(taps)
	);

	// The pin is sampled whatever its direction, so software can drive it.
	wire logic extRise = extSync2Q & ~extPrevQ;
	wire logic extFall = ~extSync2Q & extPrevQ;
	logic tick;

	always_comb begin
		unique case (clkSelQ)
			`CS_STOP: tick = 1'b0;
			`CS_DIV1: tick = 1'b1;
			`CS_DIV8: tick = taps.tick8;
			`CS_DIV64: tick = taps.tick64;
			`CS_DIV256: tick = taps.tick256;
			`CS_DIV1024: tick = taps.tick1024;
			`CS_EXT_FALL: tick = extFall;
			`CS_EXT_RISE: tick = extRise;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Counting sequence.
	always_comb begin
		countD = countQ;
		upD = upQ;
		if (wrCount) begin
			countD = wData;
		end else if (tick) begin
			if (isPhase) begin
				if (upQ && atTop) begin
					upD = 1'b0;
					countD = countQ - `COUNT_ONE;
				end else if (!upQ && atBottom) begin
					upD = 1'b1;
					countD = countQ + `COUNT_ONE;
				end else if (upQ) begin
					countD = countQ + `COUNT_ONE;
				end else begin
					countD = countQ - `COUNT_ONE;
				end
			end else if (atTop) begin
				countD = `COUNT_BOTTOM;
			end else begin
				countD = countQ + `COUNT_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare, overflow and forced compare events.
	wire logic hitA = tick & ~blockQ & (countQ == cmpAQ);
	wire logic hitB = tick & ~blockQ & (countQ == cmpBQ);
	wire logic ovfMax = (waveMode == `WM_FAST_CMP) ? atTop : (countQ == `COUNT_MAX);
	wire logic ovfHit = tick & (isPhase ? (~upQ & atBottom) : ovfMax);
	wire logic fastBottom = tick & isFast & atTop;
	// Strobes act only outside PWM and touch neither flags nor count.
	wire logic forceA = wrCtrlB & wData[`FORCE_A_BIT] & ~isPwm;
	wire logic forceB = wrCtrlB & wData[`FORCE_B_BIT] & ~isPwm;
	wire logic clrA = (wrFlags & wData[`IRQ_A_BIT]) | ackCmpA;
	wire logic clrB = (wrFlags & wData[`IRQ_B_BIT]) | ackCmpB;
	wire logic clrOvf = (wrFlags & wData[`IRQ_OVF_BIT]) | ackOvf;

	////////////////////////////////////////////////////////////////////////////
	// Read data.
	wire logic [7:0] readByte = selCtrlA ? ctrlAQ
		: selCtrlB ? {4'h0, waveHiQ, clkSelQ}
		: selCount ? countQ
		: selCmpA ? cmpAQ
		: selCmpB ? cmpBQ
		: selMask ? {3'h0, cmpAIrqEnQ, cmpBIrqEnQ, 1'h0, ovfIrqEnQ, 1'h0}
		: selFlags ? {3'h0, cmpAFlagQ, cmpBFlagQ, 1'h0, ovfFlagQ, 1'h0}
		: `REG_RESET;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave registers.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdataQ <= `WORD_ZERO;
			errQ <= 1'b0;
		end else if (setupPh) begin
			prdataQ <= apbReq.pwrite ? `WORD_ZERO : {24'h0, readByte};
			errQ <= ~mapped;
		end
	end

	assign apbRsp.pready = 1'b1;
	assign apbRsp.prdata = prdataQ;
	assign apbRsp.pslverr = accessPh & errQ;

	////////////////////////////////////////////////////////////////////////////
	// Software registers.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlAQ <= `REG_RESET;
			waveHiQ <= 1'b0;
			clkSelQ <= `CS_STOP;
			cmpAQ <= `REG_RESET;
			cmpBQ <= `REG_RESET;
		end else begin
			if (wrEn && selCtrlA) begin
				ctrlAQ <= wData & `CTRL_A_WR_MASK;
			end
			if (wrCtrlB) begin
				waveHiQ <= wData[`WAVE_HI_BIT];
				clkSelQ <= wData[`CS_MSB:`CS_LSB];
			end
			if (wrEn && selCmpA) begin
				cmpAQ <= wData;
			end
			if (wrEn && selCmpB) begin
				cmpBQ <= wData;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmpAIrqEnQ <= 1'b0;
			cmpBIrqEnQ <= 1'b0;
			ovfIrqEnQ <= 1'b0;
		end else if (wrEn && selMask) begin
			cmpAIrqEnQ <= wData[`IRQ_A_BIT];
			cmpBIrqEnQ <= wData[`IRQ_B_BIT];
			ovfIrqEnQ <= wData[`IRQ_OVF_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter, match blocking and pin synchroniser.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			countQ <= `COUNT_BOTTOM;
			upQ <= 1'b1;
			blockQ <= 1'b0;
			extSync1Q <= 1'b0;
			extSync2Q <= 1'b0;
			extPrevQ <= 1'b0;
		end else begin
			countQ <= countD;
			upQ <= upD;
			blockQ <= wrCount | (blockQ & ~tick);
			extSync1Q <= extCountPin;
			extSync2Q <= extSync1Q;
			extPrevQ <= extSync2Q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmpAFlagQ <= 1'b0;
			cmpBFlagQ <= 1'b0;
			ovfFlagQ <= 1'b0;
		end else begin
			cmpAFlagQ <= flagNext(cmpAFlagQ, hitA, clrA);
			cmpBFlagQ <= flagNext(cmpBFlagQ, hitB, clrB);
			ovfFlagQ <= flagNext(ovfFlagQ, ovfHit, clrOvf);
		end
	end

	assign irqCmpA = globalIrqEn & cmpAIrqEnQ & cmpAFlagQ;
	assign irqCmpB = globalIrqEn & cmpBIrqEnQ & cmpBFlagQ;
	assign irqOvf = globalIrqEn & ovfIrqEnQ & ovfFlagQ;

	////////////////////////////////////////////////////////////////////////////
	// Waveform outputs.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			waveAQ <= 1'b0;
			waveBQ <= 1'b0;
		end else begin
			waveAQ <= waveNext(waveAQ, outModeA, hitA, forceA, fastBottom,
				isPhase, isFast, upQ);
			waveBQ <= waveNext(waveBQ, outModeB, hitB, forceB, fastBottom,
				isPhase, isFast, upQ);
		end
	end

	assign waveOutA = waveAQ;
	assign waveOutB = waveBQ;
	assign waveConnA = outModeA != `OM_OFF;
	assign waveConnB = outModeB != `OM_OFF;

endmodule // timer0_control_and_flags
`default_nettype wire

// *** timer0_control_and_flags_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defines.svh"

module timer0_control_and_flags_monitor #(
	parameter int PreWidth = 10
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus.
	input wire timer0_pkg::apb_req_t apbReq,
	input wire timer0_pkg::apb_rsp_t apbRsp,
	// Interrupt side.
	input wire logic globalIrqEn,
	input wire logic ackCmpA,
	input wire logic ackCmpB,
	input wire logic ackOvf,
	input wire logic irqCmpA,
	input wire logic irqCmpB,
	input wire logic irqOvf,
	// Pin side.
	input wire logic extCountPin,
	input wire logic waveOutA,
	input wire logic waveOutB,
	input wire logic waveConnA,
	input wire logic waveConnB
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic wrAcc;
	logic rdAcc;
	logic [5:0] idx;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;
	assign idx = apbReq.paddr[7:2];

	////////////////////////////////////////////////////////////////////////////////
	a_irq_a_gated: assert property (irqCmpA |-> globalIrqEn)
		else $error("channel A request without global enable");
	a_irq_b_gated: assert property (irqCmpB |-> globalIrqEn)
		else $error("channel B request without global enable");
	a_irq_ovf_gated: assert property (irqOvf |-> globalIrqEn)
		else $error("overflow request without global enable");
	a_flag_a_sticky: assert property ((irqCmpA && !ackCmpA && !wrAcc) ##1 globalIrqEn |-> irqCmpA)
		else $error("channel A request dropped without a clear");
	a_flag_ovf_sticky: assert property ((irqOvf && !ackOvf && !wrAcc) ##1 globalIrqEn |-> irqOvf)
		else $error("overflow request dropped without a clear");
	a_irq_bits_zero: assert property (rdAcc && (idx == `IDX_FLAGS || idx == `IDX_MASK) |->
		!apbRsp.prdata[7] && !apbRsp.prdata[0])
		else $error("reserved interrupt bit read as one");
	a_ctrl_b_zero: assert property (rdAcc && idx == `IDX_CTRL_B |-> apbRsp.prdata[7:4] == 4'h0)
		else $error("strobe or reserved control bit read as one");
	a_conn_a_mode: assert property (wrAcc && idx == `IDX_CTRL_A |=>
		waveConnA == (|$past(apbReq.pwdata[7:6])))
		else $error("channel A connect does not follow its output mode");
	a_conn_b_mode: assert property (wrAcc && idx == `IDX_CTRL_A |=>
		waveConnB == (|$past(apbReq.pwdata[5:4])))
		else $error("channel B connect does not follow its output mode");
endmodule // timer0_control_and_flags_monitor
`default_nettype wire

// *** timer0_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module timer0_pin_model (
	// Clock.
	input wire logic clk,
	// Pins.
	output logic extCountPin,
	input wire logic waveOutA,
	input wire logic waveOutB
);
	initial extCountPin = 1'b0;

	// Drives whole pin periods, each level held past the input synchroniser.
	task automatic pulse(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			repeat (4) @(posedge clk);
			extCountPin <= 1'b1;
			repeat (4) @(posedge clk);
			extCountPin <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask
endmodule // timer0_pin_model
`default_nettype wire

// *** tb_timer0_control_and_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defines.svh"

module tb_timer0_control_and_flags;
	logic clk, sys_rst, globalIrqEn, ackCmpA, ackCmpB, ackOvf, err;
	logic irqCmpA, irqCmpB, irqOvf, extCountPin, waveOutA, waveOutB, waveConnA, waveConnB;
	logic [2:0] irqs;
	logic [31:0] rdata;
	timer0_pkg::apb_req_t apbReq;
	timer0_pkg::apb_rsp_t apbRsp;
	int n_errors = 0;
	int cmp_count = 0;
	int n;
	assign irqs = {irqOvf, irqCmpB, irqCmpA};

	timer0_control_and_flags #(.PreWidth(10)) uut (.clk(clk), .sys_rst(sys_rst),
		.apbReq(apbReq), .apbRsp(apbRsp), .globalIrqEn(globalIrqEn), .ackCmpA(ackCmpA),
		.ackCmpB(ackCmpB), .ackOvf(ackOvf), .irqCmpA(irqCmpA), .irqCmpB(irqCmpB),
		.irqOvf(irqOvf), .extCountPin(extCountPin), .waveOutA(waveOutA),
		.waveOutB(waveOutB), .waveConnA(waveConnA), .waveConnB(waveConnB));
	timer0_pin_model pins (.clk(clk), .extCountPin(extCountPin), .waveOutA(waveOutA),
		.waveOutB(waveOutB));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic timeout();
		check(32'h1, 32'h0);
		complete_run();
	endtask

	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		int k;
		@(posedge clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
			pwdata: {24'h0, wd}};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (apbRsp.pready !== 1'b1 && k < 50);
		if (k >= 50) timeout();
		rdata = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		check(exp, rdata);
	endtask

	task automatic wait_irq(input int sel, input int lim);
		n = 0;
		while (irqs[sel] !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) timeout();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic sc_regs();
		rd(`IDX_CTRL_B, 32'h0);
		wr(`IDX_CTRL_B, 8'hf8);
		rd(`IDX_CTRL_B, 32'h08);
		wr(`IDX_CTRL_B, 8'h00);
		wr(`IDX_MASK, 8'hff);
		rd(`IDX_MASK, 32'h1a);
		rd(`IDX_FLAGS, 32'h0);
		wr(`IDX_COUNT, 8'ha5);
		rd(`IDX_COUNT, 32'ha5);
		wr(`IDX_CMP_B, 8'h5a);
		rd(`IDX_CMP_B, 32'h5a);
		rd(6'h00, 32'h0);
		check(32'h1, {31'h0, err});
	endtask

	task automatic sc_match();
		wr(`IDX_CTRL_A, 8'h40);
		wr(`IDX_CMP_A, 8'h05);
		wr(`IDX_COUNT, 8'h00);
		wr(`IDX_MASK, 8'h10);
		globalIrqEn <= 1'b1;
		wr(`IDX_CTRL_B, `CS_DIV1);
		wait_irq(0, 300);
		check(32'd7, n);
		wr(`IDX_CTRL_B, `CS_STOP);
		check(32'h1, {31'h0, waveOutA});
		rd(`IDX_FLAGS, 32'h10);
		wr(`IDX_FLAGS, 8'h00);
		rd(`IDX_FLAGS, 32'h10);
		wr(`IDX_FLAGS, 8'h10);
		@(posedge clk);
		check(32'h0, {31'h0, irqCmpA});
	endtask

	task automatic sc_force();
		logic [1:0] om [3];
		logic ex [3];
		om = '{2'h3, 2'h2, 2'h1};
		ex = '{1'b1, 1'b0, 1'b1};
		wr(`IDX_COUNT, 8'h07);
		wr(`IDX_CMP_A, 8'h07);
		for (int i = 0; i < 3; i++) begin
			wr(`IDX_CTRL_A, {om[i], om[i], 4'h2});
			wr(`IDX_CTRL_B, 8'hc0);
			repeat (2) @(posedge clk);
			check({30'h0, ex[i], ex[i]}, {30'h0, waveOutA, waveOutB});
		end
		rd(`IDX_FLAGS, 32'h0);
		rd(`IDX_COUNT, 32'h07);
	endtask

	task automatic sc_suppress();
		wr(`IDX_CTRL_A, 8'h00);
		wr(`IDX_CMP_A, 8'h80);
		wr(`IDX_CMP_B, 8'h03);
		wr(`IDX_MASK, 8'h08);
		wr(`IDX_CTRL_B, `CS_DIV1);
		wr(`IDX_COUNT, 8'h03);
		wr(`IDX_CTRL_B, `CS_STOP);
		rd(`IDX_FLAGS, 32'h0);
		wr(`IDX_COUNT, 8'h02);
		wr(`IDX_CTRL_B, `CS_DIV1);
		wait_irq(1, 20);
		wr(`IDX_CTRL_B, `CS_STOP);
		rd(`IDX_FLAGS, 32'h08);
		ackCmpB <= 1'b1;
		@(posedge clk);
		ackCmpB <= 1'b0;
		@(posedge clk);
		check(32'h0, {31'h0, irqCmpB});
	endtask

	task automatic sc_ovf();
		wr(`IDX_MASK, 8'h02);
		wr(`IDX_COUNT, 8'hfd);
		wr(`IDX_CTRL_B, `CS_DIV8);
		wait_irq(2, 100);
		check(32'h1, {31'h0, n > 16 && n < 27});
		wr(`IDX_CTRL_B, `CS_STOP);
		rd(`IDX_COUNT, 32'h00);
		globalIrqEn <= 1'b0;
		repeat (2) @(posedge clk);
		check(32'h0, {31'h0, irqOvf});
		globalIrqEn <= 1'b1;
		ackOvf <= 1'b1;
		@(posedge clk);
		ackOvf <= 1'b0;
		@(posedge clk);
		check(32'h0, {31'h0, irqOvf});
		rd(`IDX_FLAGS, 32'h0);
	endtask

	task automatic sc_ext();
		wr(`IDX_COUNT, 8'h00);
		wr(`IDX_CTRL_B, `CS_EXT_RISE);
		pins.pulse(3);
		wr(`IDX_CTRL_B, `CS_STOP);
		rd(`IDX_COUNT, 32'h03);
		wr(`IDX_COUNT, 8'h00);
		wr(`IDX_CTRL_B, `CS_EXT_FALL);
		pins.pulse(2);
		wr(`IDX_CTRL_B, `CS_STOP);
		rd(`IDX_COUNT, 32'h02);
	endtask

	task automatic sc_pwm();
		wr(`IDX_CTRL_A, 8'h23);
		wr(`IDX_CMP_A, 8'h04);
		wr(`IDX_CMP_B, 8'h02);
		wr(`IDX_COUNT, 8'h00);
		wr(`IDX_CTRL_B, 8'h09);
		wait_irq(2, 20);
		check(32'd6, n);
		check(32'h1, {31'h0, waveOutB});
		wr(`IDX_CTRL_B, 8'h08);
		check(32'h0, {31'h0, waveOutB});
		rd(`IDX_FLAGS, 32'h1a);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		apbReq = '0;
		globalIrqEn = 1'b0;
		ackCmpA = 1'b0;
		ackCmpB = 1'b0;
		ackOvf = 1'b0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		sc_regs();
		sc_match();
		sc_force();
		sc_suppress();
		sc_ovf();
		sc_ext();
		sc_pwm();
		complete_run();
	end
endmodule // tb_timer0_control_and_flags

bind timer0_control_and_flags timer0_control_and_flags_monitor #(.PreWidth(PreWidth)) mon (
	.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
	.globalIrqEn(globalIrqEn), .ackCmpA(ackCmpA), .ackCmpB(ackCmpB), .ackOvf(ackOvf),
	.irqCmpA(irqCmpA), .irqCmpB(irqCmpB), .irqOvf(irqOvf), .extCountPin(extCountPin),
	.waveOutA(waveOutA), .waveOutB(waveOutB), .waveConnA(waveConnA), .waveConnB(waveConnB));
`default_nettype wire
